//--- rtl/spipc_top.sv
// SPI pin option control, slave-select role logic and bit rate generation with APB access
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module spipc_top #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_mode,
  input wire logic transfer_active,
  input wire logic tx_data_bit,
  output logic rx_data_bit,
  output logic bit_clock,
  output logic bit_tick,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic ss_in_n,
  output logic ss_out_n,
  output logic ss_oe_n,
  output logic mosi_released,
  output logic miso_released,
  output logic ss_released,
  output logic fault_detected,
  output logic clocks_stopped
);
  spipc_pkg::spipc_pin_opt_type pin_option_control;
  spipc_pkg::spipc_rate_type bit_rate_select;
  logic controller_role_select;
  logic select_output_enable;
  logic fault_detected_flag;

  // Two-stage synchronisers for pins
  logic [1:0] mosi_sync, miso_sync, ss_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mosi_sync <= 2'h0;
      miso_sync <= 2'h0;
      ss_sync <= 2'h3;
    end else begin
      mosi_sync <= {mosi_sync[0], mosi_in};
      miso_sync <= {miso_sync[0], miso_in};
      ss_sync <= {ss_sync[0], ss_in_n};
    end
  end

  // APB access: one wait state, answer from flops
  logic access;
  logic wr_done;
  logic [7:0] addr_lo;
  assign access = psel && penable;
  assign wr_done = access && pready && pwrite;
  assign addr_lo = 8'(paddr);

  logic [7:0] rd_value;
  logic addr_ok;
  always_comb begin
    rd_value = 8'h00;
    addr_ok = 1'b1;
    case (addr_lo)
      spipc_pkg::ADDR_PIN_OPT: begin
        rd_value[spipc_pkg::POC_FDE] = pin_option_control.fault_detect_enable;
        rd_value[spipc_pkg::POC_BOE] = pin_option_control.bidir_output_enable;
        rd_value[spipc_pkg::POC_WCS] = pin_option_control.wait_mode_clock_stop;
        rd_value[spipc_pkg::POC_SWM] = pin_option_control.single_wire_select;
      end
      spipc_pkg::ADDR_BIT_RATE: begin
        rd_value[spipc_pkg::BRS_PS_LSB +: spipc_pkg::PS_W] = bit_rate_select.prescale_select;
        rd_value[spipc_pkg::BRS_DIV_LSB +: spipc_pkg::DIV_W] =
          bit_rate_select.rate_divisor_select;
      end
      spipc_pkg::ADDR_ROLE: begin
        rd_value[spipc_pkg::ROLE_CTRL] = controller_role_select;
        rd_value[spipc_pkg::ROLE_SOE] = select_output_enable;
      end
      spipc_pkg::ADDR_STATUS: begin
        rd_value[spipc_pkg::ST_FAULT] = fault_detected_flag;
        rd_value[spipc_pkg::ST_STOPPED] = clocks_stopped;
        rd_value[spipc_pkg::ST_SS_REL] = ss_released;
        rd_value[spipc_pkg::ST_MOSI_REL] = mosi_released;
        rd_value[spipc_pkg::ST_MISO_REL] = miso_released;
        rd_value[spipc_pkg::ST_BITCLK] = bit_clock;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !addr_ok;
      if (access && !pready && !pwrite) begin
        prdata <= {24'h000000, rd_value};
      end
    end
  end

  // Option register, writable regardless of role or wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_option_control <= spipc_pkg::spipc_pin_opt_type'(
        {spipc_pkg::RST_PIN_OPT[spipc_pkg::POC_FDE], spipc_pkg::RST_PIN_OPT[spipc_pkg::POC_BOE],
         spipc_pkg::RST_PIN_OPT[spipc_pkg::POC_WCS], spipc_pkg::RST_PIN_OPT[spipc_pkg::POC_SWM]});
    end else if (wr_done && addr_lo == spipc_pkg::ADDR_PIN_OPT) begin
      pin_option_control.fault_detect_enable <= pwdata[spipc_pkg::POC_FDE];
      pin_option_control.bidir_output_enable <= pwdata[spipc_pkg::POC_BOE];
      pin_option_control.wait_mode_clock_stop <= pwdata[spipc_pkg::POC_WCS];
      pin_option_control.single_wire_select <= pwdata[spipc_pkg::POC_SWM];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_rate_select <= spipc_pkg::spipc_rate_type'(spipc_pkg::RST_BIT_RATE[6:0]);
    end else if (wr_done && addr_lo == spipc_pkg::ADDR_BIT_RATE) begin
      bit_rate_select.prescale_select <= pwdata[spipc_pkg::BRS_PS_LSB +: spipc_pkg::PS_W];
      bit_rate_select.rate_divisor_select <= pwdata[spipc_pkg::BRS_DIV_LSB +: spipc_pkg::DIV_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      controller_role_select <= spipc_pkg::RST_ROLE[spipc_pkg::ROLE_CTRL];
      select_output_enable <= spipc_pkg::RST_ROLE[spipc_pkg::ROLE_SOE];
    end else if (wr_done && addr_lo == spipc_pkg::ADDR_ROLE) begin
      controller_role_select <= pwdata[spipc_pkg::ROLE_CTRL];
      select_output_enable <= pwdata[spipc_pkg::ROLE_SOE];
    end
  end

  // Select pin role
  logic fde, swm, ctrl;
  logic role_fault_in, role_ss_out, role_ss_free;
  assign fde = pin_option_control.fault_detect_enable;
  assign swm = pin_option_control.single_wire_select;
  assign ctrl = controller_role_select;
  assign role_ss_free = ctrl && !fde;
  assign role_fault_in = ctrl && fde && !select_output_enable;
  assign role_ss_out = ctrl && fde && select_output_enable;

  // Sticky fault flag; set beats a write-one clear
  logic fault_set;
  assign fault_set = role_fault_in && !ss_sync[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_detected_flag <= 1'b0;
    end else if (fault_set) begin
      fault_detected_flag <= 1'b1;
    end else if (wr_done && addr_lo == spipc_pkg::ADDR_STATUS && pwdata[spipc_pkg::ST_FAULT]) begin
      fault_detected_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_out_n <= 1'b1;
      ss_oe_n <= 1'b1;
      ss_released <= 1'b0;
      fault_detected <= 1'b0;
    end else begin
      ss_out_n <= !(role_ss_out && transfer_active);
      ss_oe_n <= !role_ss_out;
      ss_released <= role_ss_free;
      fault_detected <= fault_detected_flag;
    end
  end

  // Data pin steering
  spipc_pkg::spipc_drive_type next_mosi, next_miso;
  logic next_rx, next_mosi_rel, next_miso_rel;
  always_comb begin
    next_mosi = '{out: 1'b0, oe_n: 1'b1};
    next_miso = '{out: 1'b0, oe_n: 1'b1};
    next_mosi_rel = 1'b0;
    next_miso_rel = 1'b0;
    if (!swm) begin
      if (ctrl) begin
        next_mosi = '{out: tx_data_bit, oe_n: 1'b0};
        next_rx = miso_sync[1];
      end else begin
        next_miso = '{out: tx_data_bit, oe_n: 1'b0};
        next_rx = mosi_sync[1];
      end
    end else if (ctrl) begin
      next_mosi = '{out: tx_data_bit, oe_n: !pin_option_control.bidir_output_enable};
      next_rx = mosi_sync[1];
      next_miso_rel = 1'b1;
    end else begin
      next_miso = '{out: tx_data_bit, oe_n: !pin_option_control.bidir_output_enable};
      next_rx = miso_sync[1];
      next_mosi_rel = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mosi_out <= 1'b0;
      mosi_oe_n <= 1'b1;
      miso_out <= 1'b0;
      miso_oe_n <= 1'b1;
      rx_data_bit <= 1'b0;
      mosi_released <= 1'b0;
      miso_released <= 1'b0;
    end else begin
      mosi_out <= next_mosi.out;
      mosi_oe_n <= next_mosi.oe_n;
      miso_out <= next_miso.out;
      miso_oe_n <= next_miso.oe_n;
      rx_data_bit <= next_rx;
      mosi_released <= next_mosi_rel;
      miso_released <= next_miso_rel;
    end
  end

  // Wait-mode halt; counters freeze rather than gating pclk
  logic halt;
  assign halt = wait_mode && pin_option_control.wait_mode_clock_stop;
  logic gen_clock, gen_tick;
  spipc_rate_gen #(
    .PS_W(spipc_pkg::PS_W),
    .DIV_W(spipc_pkg::DIV_W)
  ) u_rate_gen (
    .pclk(pclk),
    .presetn(presetn),
    .run(!halt),
    .rate(bit_rate_select),
    .bit_clock(gen_clock),
    .bit_tick(gen_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_clock <= 1'b0;
      bit_tick <= 1'b0;
      clocks_stopped <= 1'b0;
    end else begin
      bit_clock <= ctrl && gen_clock;
      bit_tick <= ctrl && gen_tick;
      clocks_stopped <= halt;
    end
  end

  AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready && !pwrite && addr_lo == spipc_pkg::ADDR_PIN_OPT
      |=> pready && prdata[7:5] == 3'h0 && prdata[2] == 1'b0)
    else $error("reserved option bits read nonzero");
  AST_SLAVE_SS_INPUT: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl |=> ss_oe_n && !ss_released)
    else $error("select pin not an input in slave role");
  AST_SS_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl && !fde |=> ss_released && ss_oe_n)
    else $error("select pin not released without fault detect");
  AST_SS_OUTPUT: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl && fde && select_output_enable && transfer_active |=> !ss_oe_n && !ss_out_n)
    else $error("select output not driven");
  AST_FAULT_INPUT: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl && fde && !select_output_enable && !ss_sync[1] |=> fault_detected_flag ##1 fault_detected)
    else $error("fault input not sensed");
  AST_BIDIR_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      swm && ctrl |=> mosi_oe_n == !$past(pin_option_control.bidir_output_enable))
    else $error("shared pin driver does not follow bidir enable");
  AST_SEPARATE_PINS: assert property (@(posedge pclk) disable iff (!presetn)
      !swm && ctrl |=> !mosi_oe_n && miso_oe_n && rx_data_bit == $past(miso_sync[1]))
    else $error("separate pin steering wrong");
  AST_SLAVE_SHARED: assert property (@(posedge pclk) disable iff (!presetn)
      swm && !ctrl |=> mosi_released && mosi_oe_n && rx_data_bit == $past(miso_sync[1]))
    else $error("slave shared pin steering wrong");
  AST_SEP_SLAVE: assert property (@(posedge pclk) disable iff (!presetn)
      !swm && !ctrl |=> !miso_oe_n && miso_out == $past(tx_data_bit) && !mosi_released)
    else $error("slave separate pins wrong");
  AST_CTRL_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
      swm && ctrl |=> miso_released && miso_oe_n)
    else $error("unused pin not released");
  AST_WAIT_HALT: assert property (@(posedge pclk) disable iff (!presetn)
      halt [*3] |-> ##1 clocks_stopped && $stable(bit_clock))
    else $error("clocks run in wait with stop bit set");
  AST_RATE_ANYTIME: assert property (@(posedge pclk) disable iff (!presetn)
      wr_done && addr_lo == spipc_pkg::ADDR_BIT_RATE
      |=> bit_rate_select == $past(pwdata[6:0]))
    else $error("bit rate write lost");
  AST_SLAVE_NO_CLOCK: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl |=> !bit_clock && !bit_tick)
    else $error("bit clock driven outside controller role");

  COV_SINGLE_WIRE_OUT: cover property (@(posedge pclk) disable iff (!presetn)
      swm && ctrl && !mosi_oe_n);
  COV_FAULT: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(fault_detected_flag));
  COV_WAIT_STOP: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(clocks_stopped));
  COV_BIT_TICK: cover property (@(posedge pclk) disable iff (!presetn)
      bit_tick ##[1:40] bit_tick);
endmodule

//--- inc/spipc_pkg.sv
// Package: register map, field layout and carrier types of the SPI pin and rate control
package spipc_pkg;
  localparam logic [7:0] ADDR_PIN_OPT = 8'h00;
  localparam logic [7:0] ADDR_BIT_RATE = 8'h04;
  localparam logic [7:0] ADDR_ROLE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // pin_option_control fields
  localparam int POC_FDE = 4;
  localparam int POC_BOE = 3;
  localparam int POC_WCS = 1;
  localparam int POC_SWM = 0;
  // bit_rate_select fields
  localparam int BRS_PS_LSB = 4;
  localparam int BRS_DIV_LSB = 0;
  localparam int PS_W = 3;
  localparam int DIV_W = 4;
  // role control fields
  localparam int ROLE_CTRL = 0;
  localparam int ROLE_SOE = 1;
  // status fields
  localparam int ST_FAULT = 0;
  localparam int ST_STOPPED = 1;
  localparam int ST_SS_REL = 2;
  localparam int ST_MOSI_REL = 3;
  localparam int ST_MISO_REL = 4;
  localparam int ST_BITCLK = 5;
  // Reset values
  localparam logic [7:0] RST_PIN_OPT = 8'h00;
  localparam logic [7:0] RST_BIT_RATE = 8'h00;
  localparam logic [7:0] RST_ROLE = 8'h00;
  // Highest legal divisor code, 256
  localparam logic [3:0] DIV_CODE_MAX = 4'h8;

  typedef struct packed {
    logic fault_detect_enable;
    logic bidir_output_enable;
    logic wait_mode_clock_stop;
    logic single_wire_select;
  } spipc_pin_opt_type;

  typedef struct packed {
    logic [PS_W-1:0] prescale_select;
    logic [DIV_W-1:0] rate_divisor_select;
  } spipc_rate_type;

  typedef struct packed {
    logic out;
    logic oe_n;
  } spipc_drive_type;
endpackage

//--- rtl/spipc_rate_gen.sv
// Prescaler and power-of-two divider producing the controller bit clock
`timescale 1ns/100ps
module spipc_rate_gen #(
  parameter int PS_W = 3,
  parameter int DIV_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire spipc_pkg::spipc_rate_type rate,
  output logic bit_clock,
  output logic bit_tick
);
  logic [PS_W-1:0] pre_cnt;
  logic [8:0] div_cnt;
  logic pre_tick;
  logic [DIV_W-1:0] code;
  logic [8:0] half_last;

  // Reserved codes clamp to the largest divisor
  assign code = (rate.rate_divisor_select > spipc_pkg::DIV_CODE_MAX) ?
                spipc_pkg::DIV_CODE_MAX : rate.rate_divisor_select;
  assign half_last = 9'((10'h001 << code) - 10'h001);
  assign pre_tick = run && (pre_cnt >= rate.prescale_select);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= '0;
    end else if (run) begin
      pre_cnt <= pre_tick ? '0 : pre_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      bit_clock <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (pre_tick) begin
        if (div_cnt >= half_last) begin
          div_cnt <= '0;
          bit_clock <= ~bit_clock;
          bit_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 9'h001;
        end
      end
    end
  end

  // Helper: cycles between bit ticks under a settled configuration
  logic [15:0] gap;
  logic settled;
  logic [15:0] expect_gap;
  assign expect_gap = 16'((17'(rate.prescale_select) + 17'h1) << code);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= '0;
      settled <= 1'b0;
    end else begin
      gap <= bit_tick ? 16'h0001 : gap + 16'h0001;
      if ($changed(rate) || !run) begin
        settled <= 1'b0;
      end else if (bit_tick) begin
        settled <= 1'b1;
      end
    end
  end

  AST_TICK_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
      settled && run && $stable(rate) && bit_tick |-> gap == expect_gap)
    else $error("bit tick spacing differs from prescale times divisor");
  AST_HALT_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
      !run ##1 !run |-> $stable(bit_clock))
    else $error("bit clock moved while halted");
endmodule

//--- bench/spipc_pin_model.sv
// External SPI device model on the data and select pins
`timescale 1ns/100ps
module spipc_pin_model (
  input wire logic pclk,
  input wire logic mosi_out,
  input wire logic mosi_oe_n,
  input wire logic miso_out,
  input wire logic miso_oe_n,
  input wire logic ss_out_n,
  input wire logic ss_oe_n,
  input wire logic ext_en,
  input wire logic mosi_val,
  input wire logic miso_val,
  input wire logic ss_low,
  output logic mosi_pin,
  output logic miso_pin,
  output logic ss_pin
);
  logic flip = 1'b0;
  // Undriven data lines wander, so a stale level never passes for data
  always_ff @(posedge pclk) begin
    flip <= !flip;
  end
  assign mosi_pin = !mosi_oe_n ? mosi_out : (ext_en ? mosi_val : flip);
  assign miso_pin = !miso_oe_n ? miso_out : (ext_en ? miso_val : flip);
  // Select line has a pull-up
  assign ss_pin = !ss_oe_n ? ss_out_n : !ss_low;
endmodule

//--- bench/spipc_top_test.sv
// Register, pin role, fault and bit rate tests of the SPI pin control block
`timescale 1ns/100ps
module spipc_top_test;
  localparam logic [7:0] A_OPT = spipc_pkg::ADDR_PIN_OPT;
  localparam logic [7:0] A_BR = spipc_pkg::ADDR_BIT_RATE;
  localparam logic [7:0] A_ROLE = spipc_pkg::ADDR_ROLE;
  localparam logic [7:0] A_ST = spipc_pkg::ADDR_STATUS;
  logic pclk, presetn, psel, penable, pwrite, wait_mode, transfer_active, tx_data_bit;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, rx_data_bit, bit_clock, bit_tick;
  logic mosi_in, mosi_out, mosi_oe_n, miso_in, miso_out, miso_oe_n;
  logic ss_in_n, ss_out_n, ss_oe_n;
  logic mosi_released, miso_released, ss_released, fault_detected, clocks_stopped;
  logic ext_en, mosi_val, miso_val, ss_low, c, s, b, f, o;
  logic [5:0] exp_pins;
  int errors = 0;
  int checked = 0;
  int n;

  spipc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .wait_mode, .transfer_active, .tx_data_bit, .rx_data_bit,
    .bit_clock, .bit_tick, .mosi_in, .mosi_out, .mosi_oe_n, .miso_in, .miso_out,
    .miso_oe_n, .ss_in_n, .ss_out_n, .ss_oe_n, .mosi_released, .miso_released,
    .ss_released, .fault_detected, .clocks_stopped);

  spipc_pin_model pm (.pclk, .mosi_out, .mosi_oe_n, .miso_out, .miso_oe_n, .ss_out_n,
    .ss_oe_n, .ext_en, .mosi_val, .miso_val, .ss_low, .mosi_pin(mosi_in),
    .miso_pin(miso_in), .ss_pin(ss_in_n));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task results;
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Master waits for pready with no assumed latency
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cycles until bit_tick is seen high
  task tick_gap;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (bit_tick !== 1'b1 && n < 5000);
  endtask

  task count_ticks;
    n = 0;
    repeat (20) begin
      @(posedge pclk);
      if (bit_tick === 1'b1) n++;
    end
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wait_mode = 1'b0;
    transfer_active = 1'b0;
    tx_data_bit = 1'b0;
    ext_en = 1'b1;
    mosi_val = 1'b0;
    miso_val = 1'b0;
    ss_low = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A_OPT, 0);
    check("pin_option_control reset", rd, 32'h0);
    apb(0, A_BR, 0);
    check("bit_rate_select reset", rd, 32'h0);
    apb(0, A_ST, 0);
    check("status reset", rd, 32'h0);
    apb(1, A_OPT, 32'h0000_00FF);
    apb(0, A_OPT, 0);
    check("pin_option_control bits", rd, 32'h0000_001B);
    apb(0, 8'h10, 0);
    check("unmapped error", err, 1);
    check("unmapped data", rd, 0);
    // Every role and option combination, wait clock stop left clear
    for (int i = 0; i < 32; i++) begin
      {c, o, f, b, s} = {i[4], i[3], i[2], i[0], i[1]};
      mosi_val <= i[2];
      miso_val <= !i[2];
      tx_data_bit <= i[3];
      apb(1, A_ROLE, {30'h0, o, c});
      apb(1, A_OPT, {27'h0, f, b, 2'b00, s});
      repeat (5) @(posedge pclk);
      exp_pins = {c ? s & !b : 1'b1, c ? 1'b1 : s & !b, !(c & f & o), !c & s, c & s, c & !f};
      check("pin roles", {mosi_oe_n, miso_oe_n, ss_oe_n, mosi_released, miso_released,
        ss_released}, exp_pins);
      if (!s || !b) begin
        check("rx_data_bit", rx_data_bit, (c ^ s) ? !i[2] : i[2]);
      end else begin
        check("rx loopback", rx_data_bit, i[3]);
      end
      if (!exp_pins[5]) check("mosi_out", mosi_out, i[3]);
      if (!exp_pins[4]) check("miso_out", miso_out, i[3]);
      apb(0, A_ST, 0);
      check("status releases", rd & 32'h1C, {exp_pins[1], exp_pins[2], exp_pins[0], 2'b00});
    end
    // Mode fault, then no fault without enable or as slave
    apb(1, A_ROLE, 1);
    apb(1, A_OPT, 32'h10);
    ss_low <= 1'b1;
    repeat (8) @(posedge pclk);
    check("fault_detected set", fault_detected, 1);
    ss_low <= 1'b0;
    apb(1, A_ST, 1);
    apb(0, A_ST, 0);
    check("fault flag cleared", rd[0], 0);
    apb(1, A_OPT, 0);
    ss_low <= 1'b1;
    repeat (8) @(posedge pclk);
    check("fault without enable", fault_detected, 0);
    apb(1, A_ROLE, 0);
    apb(1, A_OPT, 32'h10);
    repeat (8) @(posedge pclk);
    check("fault as slave", fault_detected, 0);
    ss_low <= 1'b0;
    // Automatic select output follows the shifter
    apb(1, A_ROLE, 3);
    transfer_active <= 1'b1;
    repeat (4) @(posedge pclk);
    check("select driven low", {ss_oe_n, ss_out_n}, 0);
    transfer_active <= 1'b0;
    repeat (4) @(posedge pclk);
    check("select idle high", {ss_oe_n, ss_out_n}, 1);
    // Rate codes written while running; codes stay at or below 1000
    for (int p = 0; p < 9; p++) begin
      apb(1, A_BR, {25'h0, p[2:0], p[3:0]});
      apb(0, A_BR, 0);
      check("bit_rate_select readback", rd, {25'h0, p[2:0], p[3:0]});
      tick_gap();
      b = bit_clock;
      tick_gap();
      check("bit_tick spacing", n, (p % 8 + 1) << p);
      check("bit_clock toggle", bit_clock, !b);
    end
    // Wait mode with and without clock stop
    apb(1, A_BR, 0);
    apb(1, A_OPT, 32'h02);
    wait_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    check("clocks_stopped", clocks_stopped, 1);
    count_ticks();
    check("ticks while stopped", n, 0);
    apb(1, A_OPT, 0);
    repeat (4) @(posedge pclk);
    check("clocks running", clocks_stopped, 0);
    count_ticks();
    check("ticks in wait", n, 20);
    wait_mode <= 1'b0;
    // Slave role has no bit clock
    apb(1, A_ROLE, 0);
    repeat (4) @(posedge pclk);
    count_ticks();
    check("slave ticks", {n[7:0], bit_clock}, 0);
    results();
  end

  // Whole run is near 5000 cycles
  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    results();
  end
endmodule
